// ### logic/mifd_decoder.sv
`timescale 1ns/10ps
`include "mifd_consts.svh"

module mifd_decoder
    import mifd_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [`MIFD_WORD_W-1:0] instr_word_in,
    input wire logic instr_valid_in,
    input wire logic pc_change_in,
    input wire logic cond_true_in,
    output logic fetch_req_out,
    output logic [`MIFD_PHASE_W-1:0] phase_out,
    output logic cycle_start_out,
    output logic decoded_valid_out,
    output logic no_operation_out,
    output logic two_cycle_out,
    output mifd_fields_s decoded_out
);

    // ****************************************************************
    // reset synchroniser
    // ****************************************************************
    logic rst_meta_n;
    logic rst_n;

    // two stages, asynchronous assert, clocked release
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ****************************************************************
    // instruction cycle sequencer
    // ****************************************************************
    logic [`MIFD_PHASE_W-1:0] phase;
    logic last_phase;

    mifd_phase_counter #(
        .PHASES(`MIFD_PHASES),
        .PHASE_W(`MIFD_PHASE_W)
    ) u_phase (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .phase_out(phase),
        .last_out(last_phase)
    );

    // ****************************************************************
    // field extraction, purely combinational
    // ****************************************************************
    mifd_fields_s next_fields;
    mifd_class_e word_class;

    // one-hot mask for the selected bit of an eight-bit register
    function automatic logic [`MIFD_REG_W-1:0] mifd_bit_mask(
        input logic [`MIFD_BITNUM_W-1:0] num
    );
        logic [`MIFD_REG_W-1:0] mask;
        mask = '0;
        mask[num] = 1'b1;
        return mask;
    endfunction

    // class from the two top bits only, so lower don't-cares never steer it
    assign word_class = mifd_class_e'(instr_word_in[`MIFD_CLASS_MSB:`MIFD_CLASS_LSB]); // RULE2

    // each class picks only the bits of its own format
    always_comb begin
        next_fields = '0; // RULE10
        next_fields.insn_class = word_class;
        case (word_class)
            MIFD_CLS_BYTE: begin
                next_fields.opcode = `MIFD_OPC_W'(
                    instr_word_in[`MIFD_CLASS_MSB:`MIFD_BYTE_OPC_LSB]);
                next_fields.file_addr = instr_word_in[`MIFD_FILE_MSB:0]; // RULE3
                if (instr_word_in[`MIFD_DEST_BIT]) begin
                    next_fields.write_file = 1'b1; // RULE5
                    next_fields.write_acc = 1'b0; // RULE5
                end else begin
                    next_fields.write_acc = 1'b1; // RULE4
                    next_fields.write_file = 1'b0; // RULE4
                end
            end
            MIFD_CLS_BIT: begin
                next_fields.opcode = `MIFD_OPC_W'(
                    instr_word_in[`MIFD_CLASS_MSB:`MIFD_BIT_OPC_LSB]); // RULE7
                next_fields.bit_num =
                    instr_word_in[`MIFD_BITNUM_MSB:`MIFD_BITNUM_LSB]; // RULE7
                next_fields.file_addr = instr_word_in[`MIFD_FILE_MSB:0]; // RULE7
                next_fields.bit_mask = mifd_bit_mask(
                    instr_word_in[`MIFD_BITNUM_MSB:`MIFD_BITNUM_LSB]); // RULE6
            end
            MIFD_CLS_JUMP: begin
                next_fields.is_call_jump = 1'b1;
                next_fields.opcode = `MIFD_OPC_W'(
                    instr_word_in[`MIFD_CLASS_MSB:`MIFD_JMP_OPC_LSB]); // RULE9
                next_fields.target = instr_word_in[`MIFD_TGT_MSB:0]; // RULE9
            end
            MIFD_CLS_LIT: begin
                next_fields.opcode = `MIFD_OPC_W'(
                    instr_word_in[`MIFD_CLASS_MSB:`MIFD_LIT_OPC_LSB]); // RULE8
                next_fields.literal = instr_word_in[`MIFD_LIT_MSB:0]; // RULE8
            end
            default: begin
                next_fields = '0;
            end
        endcase
    end

    // ****************************************************************
    // redirect tracking during the current cycle
    // ****************************************************************
    logic redirect_seen;
    logic redirect_now;
    mifd_state_e state;
    mifd_state_e next_state;

    // a change seen in the last phase counts as well
    assign redirect_now = redirect_seen | pc_change_in | cond_true_in;

    // sticky within one instruction cycle, cleared at its end
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            redirect_seen <= 1'b0;
        end else if (last_phase) begin
            redirect_seen <= 1'b0;
        end else if (state == MIFD_ST_EXEC && (pc_change_in || cond_true_in)) begin
            redirect_seen <= 1'b1;
        end
    end

    // ****************************************************************
    // sequencer state choice at each cycle boundary
    // ****************************************************************
    always_comb begin
        next_state = state;
        case (state)
            MIFD_ST_IDLE: begin
                if (instr_valid_in) begin
                    next_state = MIFD_ST_EXEC;
                end
            end
            MIFD_ST_EXEC: begin
                if (redirect_now || decoded_out.is_call_jump) begin
                    next_state = MIFD_ST_FLUSH; // RULE12
                end else if (instr_valid_in) begin
                    next_state = MIFD_ST_EXEC; // RULE11
                end else begin
                    next_state = MIFD_ST_IDLE;
                end
            end
            MIFD_ST_FLUSH: begin
                if (instr_valid_in) begin
                    next_state = MIFD_ST_EXEC;
                end else begin
                    next_state = MIFD_ST_IDLE;
                end
            end
            default: begin
                next_state = MIFD_ST_IDLE;
            end
        endcase
    end

    // state moves only on the instruction cycle enable
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= MIFD_ST_IDLE;
        end else if (last_phase) begin
            state <= next_state; // RULE13
        end
    end

    // ****************************************************************
    // decoded outputs, loaded at the cycle boundary
    // ****************************************************************
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            decoded_out <= '0;
        end else if (last_phase) begin
            if (next_state == MIFD_ST_EXEC) begin
                decoded_out <= next_fields; // RULE1
            end else begin
                decoded_out <= '0; // RULE12
            end
        end
    end

    // valid and no-operation markers for the coming cycle
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            decoded_valid_out <= 1'b0;
            no_operation_out <= 1'b0;
        end else if (last_phase) begin
            decoded_valid_out <= (next_state == MIFD_ST_EXEC);
            no_operation_out <= (next_state == MIFD_ST_FLUSH); // RULE12
        end
    end

    // marks a jump, or an instruction redirected before its last phase, whose second cycle is a no-operation
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            two_cycle_out <= 1'b0;
        end else if (last_phase) begin
            two_cycle_out <= 1'b0;
        end else if (state == MIFD_ST_EXEC) begin
            two_cycle_out <= redirect_seen | pc_change_in | cond_true_in
                | decoded_out.is_call_jump; // RULE12
        end
    end

    // ****************************************************************
    // timing outputs
    // ****************************************************************
    // fetch request held in the phase before the word is sampled
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            fetch_req_out <= 1'b0;
        end else begin
            fetch_req_out <= (phase == `MIFD_PHASE_FETCH);
        end
    end

    // phase copy and one-cycle start pulse
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            phase_out <= `MIFD_PHASE_RST;
            cycle_start_out <= 1'b0;
        end else begin
            phase_out <= phase; // RULE13
            cycle_start_out <= last_phase;
        end
    end

endmodule

// ### logic/mifd_consts.svh
// Notes on behaviour
// RULE1: every instruction is one fourteen-bit word
// RULE2: sort into byte, bit, literal-control classes
// RULE3: file operand is seven bits, 0x00-0x7f
// RULE4: destination bit 0 writes the accumulator
// RULE5: destination bit 1 writes file, accumulator kept
// RULE6: bit number picks one of eight bits
// RULE7: bit ops: opcode 13-10, bit 9-7, file 6-0
// RULE8: literal ops: opcode 13-8, constant 7-0
// RULE9: jump and call: opcode 13-11, target 10-0
// RULE10: don't-care bits never change decoding
// RULE11: plain instructions finish in one cycle
// RULE12: branch or true test adds a no-operation cycle
// RULE13: one instruction cycle is four clock phases
// RULE14: programs avoid option and direction loads
`ifndef MIFD_CONSTS_SVH
`define MIFD_CONSTS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define MIFD_WORD_W 14
`define MIFD_FILE_W 7
`define MIFD_BITNUM_W 3
`define MIFD_REG_W 8
`define MIFD_LIT_W 8
`define MIFD_TGT_W 11
`define MIFD_OPC_W 6
`define MIFD_PHASES 4
`define MIFD_PHASE_W 2

// ****************************************************************
// field positions
// ****************************************************************
`define MIFD_CLASS_MSB 13
`define MIFD_CLASS_LSB 12
`define MIFD_JMPSEL_BIT 11
`define MIFD_BYTE_OPC_LSB 8
`define MIFD_DEST_BIT 7
`define MIFD_FILE_MSB 6
`define MIFD_BIT_OPC_LSB 10
`define MIFD_BITNUM_MSB 9
`define MIFD_BITNUM_LSB 7
`define MIFD_LIT_OPC_LSB 8
`define MIFD_LIT_MSB 7
`define MIFD_JMP_OPC_LSB 11
`define MIFD_TGT_MSB 10

// ****************************************************************
// reset values and phase numbers
// ****************************************************************
`define MIFD_PHASE_RST 2'h0
`define MIFD_PHASE_FETCH 2'h1
`define MIFD_PHASE_LAST 2'h3
`define MIFD_OPC_RST 6'h00
`define MIFD_FILE_RST 7'h00
`define MIFD_LIT_RST 8'h00
`define MIFD_TGT_RST 11'h000
`define MIFD_BITNUM_RST 3'h0
`define MIFD_MASK_RST 8'h00

`endif

// ### logic/mifd_pkg.sv
`include "mifd_consts.svh"

package mifd_pkg;

    // ****************************************************************
    // instruction classes from word bits 13:12
    // ****************************************************************
    typedef enum logic [1:0] {
        MIFD_CLS_BYTE = 2'b00,
        MIFD_CLS_BIT = 2'b01,
        MIFD_CLS_JUMP = 2'b10,
        MIFD_CLS_LIT = 2'b11
    } mifd_class_e;

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        MIFD_ST_IDLE = 2'b00,
        MIFD_ST_EXEC = 2'b01,
        MIFD_ST_FLUSH = 2'b10
    } mifd_state_e;

    typedef logic [`MIFD_WORD_W-1:0] mifd_word_t;

    // ****************************************************************
    // decoded operand fields
    // ****************************************************************
    typedef struct packed {
        mifd_class_e insn_class;
        logic is_call_jump;
        logic [`MIFD_OPC_W-1:0] opcode;
        logic [`MIFD_FILE_W-1:0] file_addr;
        logic write_acc;
        logic write_file;
        logic [`MIFD_BITNUM_W-1:0] bit_num;
        logic [`MIFD_REG_W-1:0] bit_mask;
        logic [`MIFD_LIT_W-1:0] literal;
        logic [`MIFD_TGT_W-1:0] target;
    } mifd_fields_s;

endpackage

// ### logic/mifd_phase_counter.sv
`timescale 1ns/10ps
`include "mifd_consts.svh"

module mifd_phase_counter
    import mifd_pkg::*;
#(
    parameter int PHASES = `MIFD_PHASES,
    parameter int PHASE_W = `MIFD_PHASE_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    output logic [PHASE_W-1:0] phase_out,
    output logic last_out
);

    localparam logic [PHASE_W-1:0] LAST = PHASE_W'(PHASES - 1);

    // ****************************************************************
    // oscillator phase count, wraps once per instruction cycle
    // ****************************************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_out <= '0;
        end else if (phase_out == LAST) begin
            phase_out <= '0; // RULE13
        end else begin
            phase_out <= phase_out + PHASE_W'(1);
        end
    end

    // one-cycle enable in the last phase
    assign last_out = (phase_out == LAST);

endmodule

// ### tb/mifd_decoder_properties.sv
`timescale 1ns/10ps
`include "mifd_consts.svh"

module mifd_decoder_properties
    import mifd_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [`MIFD_WORD_W-1:0] instr_word_in,
    input wire logic instr_valid_in,
    input wire logic pc_change_in,
    input wire logic cond_true_in,
    input wire logic fetch_req_out,
    input wire logic [`MIFD_PHASE_W-1:0] phase_out,
    input wire logic cycle_start_out,
    input wire logic decoded_valid_out,
    input wire logic no_operation_out,
    input wire logic two_cycle_out,
    input wire mifd_fields_s decoded_out
);
    // ****
    // clocking and step sequences
    // ****
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    sequence fetch_gap_seq; !fetch_req_out [*3] ##1 fetch_req_out; endsequence
    sequence start_gap_seq; !cycle_start_out [*3] ##1 cycle_start_out; endsequence
    sequence flush_cycle_seq; no_operation_out [*4] ##1 !no_operation_out; endsequence
    sequence new_word_seq; cycle_start_out && decoded_valid_out; endsequence
    sequence byte_word_seq; new_word_seq ##0 decoded_out.insn_class == MIFD_CLS_BYTE; endsequence
    sequence bit_word_seq; new_word_seq ##0 decoded_out.insn_class == MIFD_CLS_BIT; endsequence
    sequence lit_word_seq; new_word_seq ##0 decoded_out.insn_class == MIFD_CLS_LIT; endsequence
    sequence jump_word_seq; new_word_seq ##0 decoded_out.insn_class == MIFD_CLS_JUMP; endsequence

    // timing of the four-phase cycle
    fetch_period_a: assert property (fetch_req_out |=> fetch_gap_seq)
        else $error("fetch request not every four clocks");
    fetch_phase_a: assert property (fetch_req_out |-> phase_out == 2'h1)
        else $error("fetch request in wrong phase");
    start_align_a: assert property (cycle_start_out |-> phase_out == 2'h3 ##1 start_gap_seq)
        else $error("cycle start misplaced");
    decoded_hold_a: assert property (!cycle_start_out |-> $stable(decoded_out))
        else $error("decoded fields moved mid cycle");
    // operand extraction per class
    class_map_a: assert property (new_word_seq |->
        decoded_out.insn_class == $past(instr_word_in[13:12]))
        else $error("class wrong");
    byte_fields_a: assert property (byte_word_seq |->
        decoded_out.file_addr == $past(instr_word_in[6:0])
        && decoded_out.write_file == $past(instr_word_in[7])
        && decoded_out.write_acc == !$past(instr_word_in[7]))
        else $error("byte fields wrong");
    bit_fields_a: assert property (bit_word_seq |->
        decoded_out.bit_num == $past(instr_word_in[9:7])
        && decoded_out.bit_mask == (8'h01 << $past(instr_word_in[9:7]))
        && decoded_out.file_addr == $past(instr_word_in[6:0])
        && decoded_out.opcode == {2'h0, $past(instr_word_in[13:10])})
        else $error("bit fields wrong");
    lit_fields_a: assert property (lit_word_seq |->
        decoded_out.literal == $past(instr_word_in[7:0])
        && decoded_out.opcode == $past(instr_word_in[13:8]))
        else $error("literal wrong");
    jump_fields_a: assert property (jump_word_seq |->
        decoded_out.target == $past(instr_word_in[10:0]))
        else $error("target wrong");
    // two-cycle instructions
    jump_flush_a: assert property (jump_word_seq |-> ##[0:1] two_cycle_out)
        else $error("jump not two cycles");
    redirect_flush_a: assert property (two_cycle_out && phase_out == 2'h2 |=>
        no_operation_out && !decoded_valid_out && decoded_out == '0)
        else $error("no flush");
    nop_length_a: assert property ($rose(no_operation_out) |-> flush_cycle_seq)
        else $error("flush cycle length wrong");
    single_cycle_a: assert property (phase_out == 2'h2 && decoded_valid_out
        && !two_cycle_out && !pc_change_in && !cond_true_in |=> !no_operation_out)
        else $error("extra cycle");
endmodule

// ### tb/mifd_prog_mem.sv
`timescale 1ns/10ps
`include "mifd_consts.svh"

module mifd_prog_mem
    import mifd_pkg::*;
(
    input wire logic clk_in,
    input wire logic fetch_req_in,
    input wire logic slow_in,
    input wire logic [`MIFD_WORD_W-1:0] word_in,
    input wire logic valid_in,
    output logic [`MIFD_WORD_W-1:0] instr_word_out,
    output logic instr_valid_out
);
    logic pending;

    initial begin
        instr_word_out = '0;
        instr_valid_out = 1'b0;
        pending = 1'b0;
    end

    // drive on fetch or one clock later when slow, hold to the sample edge
    always @(negedge clk_in) begin
        pending <= fetch_req_in;
        if ((fetch_req_in && !slow_in) || (pending && slow_in)) begin
            instr_word_out <= word_in;
            instr_valid_out <= valid_in;
        end else if (!pending) begin
            instr_word_out <= ~instr_word_out; // released bus keeps changing
            instr_valid_out <= 1'b0;
        end
    end
endmodule

// ### tb/mifd_decoder_tb.sv
`timescale 1ns/10ps

module mifd_decoder_tb
    import mifd_pkg::*;
;
    localparam int FW = $bits(mifd_fields_s);
    logic clk_sys_in, resetn_in, pc_change_in, cond_true_in, instr_valid_in;
    logic fetch_req_out, cycle_start_out, decoded_valid_out, no_operation_out, two_cycle_out;
    logic [1:0] phase_out;
    mifd_word_t instr_word_in, mem_word;
    logic mem_valid, mem_slow;
    mifd_fields_s decoded_out;
    int n_fail = 0;
    int checked = 0;

    mifd_decoder mifd_decoder_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .instr_word_in(instr_word_in), .instr_valid_in(instr_valid_in),
        .pc_change_in(pc_change_in), .cond_true_in(cond_true_in), .fetch_req_out(fetch_req_out),
        .phase_out(phase_out), .cycle_start_out(cycle_start_out),
        .decoded_valid_out(decoded_valid_out), .no_operation_out(no_operation_out),
        .two_cycle_out(two_cycle_out), .decoded_out(decoded_out));
    mifd_prog_mem mifd_prog_mem_inst (.clk_in(clk_sys_in), .fetch_req_in(fetch_req_out),
        .slow_in(mem_slow), .word_in(mem_word), .valid_in(mem_valid),
        .instr_word_out(instr_word_in), .instr_valid_out(instr_valid_in));

    // ****
    // shared tasks
    // ****
    task automatic give_verdict();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [FW-1:0] seen, input logic [FW-1:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ran_out();
        n_fail++;
        $display("wrong value at %0t: wait ran out", $time);
        give_verdict();
    endtask

    // expected operand fields of one word, unused fields zero
    function automatic mifd_fields_s exp_fields(input mifd_word_t w);
        mifd_fields_s f;
        f = '0;
        f.insn_class = mifd_class_e'(w[13:12]);
        case (f.insn_class)
            MIFD_CLS_BYTE: begin
                f.opcode = w[13:8];
                f.write_file = w[7];
                f.write_acc = ~w[7];
                f.file_addr = w[6:0];
            end
            MIFD_CLS_BIT: begin
                f.opcode = {2'h0, w[13:10]};
                f.bit_num = w[9:7];
                f.bit_mask = 8'h01 << w[9:7];
                f.file_addr = w[6:0];
            end
            MIFD_CLS_JUMP: begin
                f.opcode = {3'h0, w[13:11]};
                f.target = w[10:0];
                f.is_call_jump = 1'b1;
            end
            default: begin
                f.opcode = w[13:8];
                f.literal = w[7:0];
            end
        endcase
        return f;
    endfunction

    // one word through program memory; redir bit0 pc change, bit1 true test
    task automatic issue(input mifd_word_t w, input logic v, input logic slow, input logic no_operation,
        input logic [1:0] redir);
        mifd_fields_s ef;
        logic et;
        ef = (v && !no_operation) ? exp_fields(w) : '0;
        et = redir != 2'h0 || (v && !no_operation && w[13:12] == 2'h2);
        mem_word = w;
        mem_valid = v;
        mem_slow = slow;
        repeat (16) if (fetch_req_out !== 1'b1) @(negedge clk_sys_in);
        if (fetch_req_out !== 1'b1) ran_out();
        @(negedge clk_sys_in);
        repeat (8) if (cycle_start_out !== 1'b1) @(negedge clk_sys_in);
        if (cycle_start_out !== 1'b1) ran_out();
        check(decoded_out, ef);
        check(FW'({decoded_valid_out, no_operation_out, phase_out}), FW'({v && !no_operation, no_operation, 2'h3}));
        pc_change_in = redir[0];
        cond_true_in = redir[1];
        @(negedge clk_sys_in);
        pc_change_in = 1'b0;
        cond_true_in = 1'b0;
        check(FW'(two_cycle_out), FW'(et));
    endtask

    // ****
    // scenarios, no option or direction load words among them
    // ****
    task automatic byte_ops();
        issue(14'h0780, 1'b1, 1'b0, 1'b0, 2'h0);
        issue(14'h077f, 1'b1, 1'b1, 1'b0, 2'h0);
    endtask

    task automatic bit_ops();
        for (int i = 0; i < 8; i++) begin
            issue({4'h6, i[2:0], 7'h2a}, 1'b1, i[0], 1'b0, 2'h0);
        end
    endtask

    task automatic lit_ops();
        issue(14'h3000, 1'b1, 1'b0, 1'b0, 2'h0);
        issue(14'h3fff, 1'b1, 1'b1, 1'b0, 2'h0);
    endtask

    task automatic jump_ops();
        issue(14'h2fff, 1'b1, 1'b0, 1'b0, 2'h0);
        issue(14'h0a25, 1'b1, 1'b0, 1'b1, 2'h0);
        issue(14'h2800, 1'b1, 1'b1, 1'b0, 2'h0);
        issue(14'h2123, 1'b1, 1'b0, 1'b1, 2'h0);
    endtask

    task automatic redirect_ops();
        issue(14'h0a25, 1'b1, 1'b0, 1'b0, 2'h1);
        issue(14'h1d00, 1'b1, 1'b0, 1'b1, 2'h0);
        issue(14'h1d00, 1'b1, 1'b0, 1'b0, 2'h2);
        issue(14'h3a5a, 1'b1, 1'b0, 1'b1, 2'h0);
        issue(14'h0a25, 1'b1, 1'b0, 1'b0, 2'h0);
        issue(14'h1234, 1'b0, 1'b0, 1'b0, 2'h0);
    endtask

    // redirect raised only in the last phase, then held into the flush cycle
    task automatic late_redirect();
        issue(14'h0a25, 1'b1, 1'b0, 1'b0, 2'h0);
        repeat (2) @(negedge clk_sys_in);
        pc_change_in = 1'b1;
        cond_true_in = 1'b1;
        @(negedge clk_sys_in);
        check(FW'({no_operation_out, decoded_valid_out}), FW'(2'h2));
        check(decoded_out, '0);
        @(negedge clk_sys_in);
        pc_change_in = 1'b0;
        cond_true_in = 1'b0;
        check(FW'(two_cycle_out), FW'(1'b0));
        issue(14'h0a25, 1'b1, 1'b0, 1'b0, 2'h0);
    endtask

    task automatic reset_mid();
        resetn_in = 1'b0;
        @(negedge clk_sys_in);
        check(FW'({fetch_req_out, cycle_start_out, decoded_valid_out, phase_out}), '0);
        repeat (3) @(negedge clk_sys_in);
        resetn_in = 1'b1;
        issue(14'h0b7f, 1'b1, 1'b0, 1'b0, 2'h0);
    endtask

    // ****
    // clock, reset and main sequence
    // ****
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        resetn_in = 1'b0;
        pc_change_in = 1'b0;
        cond_true_in = 1'b0;
        mem_word = '0;
        mem_valid = 1'b0;
        mem_slow = 1'b0;
        repeat (16) @(negedge clk_sys_in);
        resetn_in = 1'b1;
        byte_ops();
        bit_ops();
        lit_ops();
        jump_ops();
        redirect_ops();
        late_redirect();
        reset_mid();
        give_verdict();
    end
endmodule

bind mifd_decoder mifd_decoder_properties mifd_decoder_properties_inst (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .instr_word_in(instr_word_in),
    .instr_valid_in(instr_valid_in), .pc_change_in(pc_change_in), .cond_true_in(cond_true_in),
    .fetch_req_out(fetch_req_out), .phase_out(phase_out), .cycle_start_out(cycle_start_out),
    .decoded_valid_out(decoded_valid_out), .no_operation_out(no_operation_out),
    .two_cycle_out(two_cycle_out), .decoded_out(decoded_out));
